// ===== rtl/stx_serial_in.sv
/*
  stx_serial_in: serial audio input stage of a biphase-mark transmitter.
  deserialises stereo words, queues them in a fifo, divides the oversampling
  clock into the biphase coding clock, and produces the loop-mode clocks.
  assumes: bit clock, frame clock and data arrive from outside and are
  slower than clock / 4; oversample_clock_in is likewise sampled.
*/
`timescale 1ns/100ps
// Summary of operation
// - accepts right-justified, I2S, left-justified; words of 16, 18, 20 or 24 bits
// - right- and left-justified: frame clock high is left, low is right
// - data line sampled on rising bit-clock edges, shifted in only from start_slot until word_bits are taken
// - right-justified msb starts 12 periods (20-bit) or 16 periods (16-bit) late
// - right-justified uses 64 bit clocks per frame; lsb ends at transition
// - I2S is reset default; frame clock low is left, high is right
// - I2S msb appears one bit-clock period after the transition
// - left-justified msb appears in the first period, no delay
// - biphase coding clock is the oversampling clock divided down
// - loop mode produces a recovered clock at 512 times frame rate
// - loop mode bit clock is 64 times frame clock; frame and data follow it
module stx_serial_in
  import stx_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [1:0] format_sel,
  input wire logic [1:0] width_sel,
  input wire logic bit_clock_in,
  input wire logic frame_clock_in,
  input wire logic serial_audio_line,
  input wire logic oversample_clock_in,
  input wire logic [7:0] biphase_div,
  output logic biphase_clock,
  output logic sample_valid,
  input wire logic sample_ready,
  output logic [STX_WORD_W-1:0] sample_left,
  output logic [STX_WORD_W-1:0] sample_right,
  output logic overflow,
  input wire logic loop_mode,
  input wire logic loop_serial_bit,
  output logic recovered_clock,
  output logic loop_bit_clock,
  output logic loop_frame_clock,
  output logic loop_serial_out
);

  typedef struct packed {
    logic [1:0] bck_s;
    logic [1:0] fck_s;
    logic [1:0] dat_s;
    logic [1:0] osc_s;
    logic bck_d;
    logic fck_d;
    logic osc_d;
    logic [5:0] slot;
    logic [4:0] got;
    logic [STX_WORD_W-1:0] shreg;
    logic [STX_WORD_W-1:0] left;
    logic cur_left;
    logic push;
    logic [STX_WORD_W-1:0] hold_l;
    logic [STX_WORD_W-1:0] hold_r;
    logic ovf;
    logic [7:0] divc;
    logic bph;
    logic [4:0] lbdiv;
    logic lbclk;
    logic [5:0] lbcnt;
    logic lfck;
    logic lsd;
    logic [1:0] rdiv;
    logic rclk;
  } stx_st_s;

  stx_st_s st_r;
  stx_st_s st_nxt;
  logic [4:0] word_bits;
  logic [5:0] start_slot;
  logic is_left;
  logic fifo_ready;
  logic [2*STX_WORD_W-1:0] fifo_out;

  ////////////////////////////////////////////////////////////////////////////
  // format decode

  always_comb begin
    case (width_sel)
      STX_W16: word_bits = 5'd16;
      STX_W18: word_bits = 5'd18;
      STX_W20: word_bits = 5'd20;
      default: word_bits = 5'd24;
    endcase
    case (format_sel)
      STX_FMT_LJ: start_slot = STX_LJ_DELAY;
      STX_FMT_RJ: start_slot = STX_RJ_SLOTS - 6'(word_bits);
      default: start_slot = STX_I2S_DELAY;
    endcase
    if (format_sel == STX_FMT_LJ || format_sel == STX_FMT_RJ) begin
      is_left = st_r.fck_s[1];
    end else begin
      is_left = !st_r.fck_s[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture, divider, loop clocks

  always_comb begin
    st_nxt = st_r;
    st_nxt.bck_s = {st_r.bck_s[0], bit_clock_in};
    st_nxt.fck_s = {st_r.fck_s[0], frame_clock_in};
    st_nxt.dat_s = {st_r.dat_s[0], serial_audio_line};
    st_nxt.osc_s = {st_r.osc_s[0], oversample_clock_in};
    st_nxt.bck_d = st_r.bck_s[1];
    st_nxt.osc_d = st_r.osc_s[1];
    st_nxt.push = 1'b0;
    if (st_r.bck_s[1] && !st_r.bck_d) begin
      st_nxt.fck_d = st_r.fck_s[1];
      if (st_r.fck_s[1] != st_r.fck_d) begin
        st_nxt.slot = 6'd1;
        st_nxt.got = '0;
        st_nxt.cur_left = is_left;
        st_nxt.shreg = '0;
        if (start_slot == 6'd0) begin
          st_nxt.shreg = STX_WORD_W'(st_r.dat_s[1]);
          st_nxt.got = 5'd1;
        end
      end else begin
        st_nxt.slot = st_r.slot + 6'd1;
        if (st_r.slot >= start_slot && st_r.got < word_bits) begin
          st_nxt.shreg = {st_r.shreg[STX_WORD_W-2:0], st_r.dat_s[1]};
          st_nxt.got = st_r.got + 5'd1;
        end
      end
      if (st_nxt.got == word_bits && st_r.got != word_bits) begin
        if (st_r.cur_left || (st_r.fck_s[1] != st_r.fck_d && is_left)) begin
          st_nxt.left = st_nxt.shreg;
        end else begin
          st_nxt.hold_l = st_r.left;
          st_nxt.hold_r = st_nxt.shreg;
          st_nxt.push = 1'b1;
          st_nxt.ovf = !fifo_ready;
        end
      end
    end
    if (st_r.osc_s[1] && !st_r.osc_d) begin
      if (st_r.divc >= biphase_div) begin
        st_nxt.divc = '0;
        st_nxt.bph = !st_r.bph;
      end else begin
        st_nxt.divc = st_r.divc + 8'd1;
      end
    end
    // recovered clock: clock/4, loop bit clock = recovered/8 -> 512 vs 64
    st_nxt.rdiv = st_r.rdiv + 2'd1;
    if (st_r.rdiv == 2'd1 || st_r.rdiv == 2'd3) begin
      st_nxt.rclk = !st_r.rclk;
    end
    if (loop_mode) begin
      st_nxt.lbdiv = st_r.lbdiv + 5'd1;
      if (st_r.lbdiv == (5'(STX_BCLK_HALF) << 2) - 5'd1) begin
        st_nxt.lbdiv = '0;
        st_nxt.lbclk = !st_r.lbclk;
        if (st_r.lbclk) begin
          st_nxt.lbcnt = st_r.lbcnt + 6'd1;
          // low five bits only: the frame clock toggles every 32 bit clocks
          if (st_r.lbcnt[4:0] == 5'(STX_LOOP_BCLK_RATIO / 7'h2 - 7'h1)) begin
            st_nxt.lfck = !st_r.lfck;
          end
          st_nxt.lsd = loop_serial_bit;
        end
      end
    end else begin
      st_nxt.lbdiv = '0;
      st_nxt.lbclk = 1'b0;
      st_nxt.lbcnt = '0;
      st_nxt.lfck = 1'b0;
      st_nxt.lsd = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.divc <= STX_BIPHASE_DIV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output queue

  stx_fifo #(
    .WIDTH(2*STX_WORD_W),
    .DEPTH(STX_FIFO_DEPTH),
    .AW(STX_FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(st_r.push),
    .in_ready(fifo_ready),
    .in_data({st_r.hold_l, st_r.hold_r}),
    .out_valid(sample_valid),
    .out_ready(sample_ready),
    .out_data(fifo_out)
  );

  assign sample_left = fifo_out[2*STX_WORD_W-1:STX_WORD_W];
  assign sample_right = fifo_out[STX_WORD_W-1:0];
  assign overflow = st_r.ovf;
  assign biphase_clock = st_r.bph;
  assign recovered_clock = st_r.rclk;
  assign loop_bit_clock = st_r.lbclk;
  assign loop_frame_clock = st_r.lfck;
  assign loop_serial_out = st_r.lsd;

endmodule : stx_serial_in

// ===== rtl/stx_pkg.sv
/*
  stx_pkg: constants and types shared by the serial audio input stage.
  assumes: included before every design file of the block.
*/
package stx_pkg;

  typedef enum logic [1:0] {
    STX_FMT_I2S = 2'h0,
    STX_FMT_LJ  = 2'h1,
    STX_FMT_RJ  = 2'h2
  } stx_fmt_e;

  typedef enum logic [1:0] {
    STX_W16 = 2'h0,
    STX_W18 = 2'h1,
    STX_W20 = 2'h2,
    STX_W24 = 2'h3
  } stx_width_e;

  localparam int STX_WORD_W = 24;
  localparam int STX_FIFO_DEPTH = 16;
  localparam int STX_FIFO_AW = 4;
  localparam logic [5:0] STX_RJ_SLOTS = 6'h20;
  localparam logic [5:0] STX_RJ_DELAY_20 = 6'h0c;
  localparam logic [5:0] STX_RJ_DELAY_16 = 6'h10;
  localparam logic [5:0] STX_I2S_DELAY = 6'h01;
  localparam logic [5:0] STX_LJ_DELAY = 6'h00;
  localparam logic [9:0] STX_RECOV_RATIO = 10'h200;
  localparam logic [6:0] STX_LOOP_BCLK_RATIO = 7'h40;
  localparam logic [7:0] STX_BIPHASE_DIV_RST = 8'h00;
  localparam logic [4:0] STX_BCLK_HALF = 5'h04;

endpackage : stx_pkg

// ===== rtl/stx_fifo.sv
/*
  stx_fifo: synchronous fifo with valid/ready on both sides.
  assumes: single clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
module stx_fifo
  import stx_pkg::*;
#(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] dout;
    logic dval;
  } stx_fifo_s;

  stx_fifo_s st_r;
  stx_fifo_s st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic push;
  logic pop;
  logic load;

  // the output register counts as one of the DEPTH words
  assign in_ready = ((st_r.cnt + (AW+1)'(st_r.dval)) != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign load = (st_r.cnt != '0) && (!st_r.dval || out_ready);
  assign pop = load;
  assign out_valid = st_r.dval;
  assign out_data = st_r.dout;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + AW'(1);
    end
    if (out_ready && st_r.dval) begin
      st_nxt.dval = 1'b0;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + AW'(1);
      st_nxt.dout = mem_r[st_r.rp];
      st_nxt.dval = 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[st_r.wp] <= in_data;
    end
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : stx_fifo

// ===== verif/stx_src.sv
/* stx_src: serial audio source driving bit clock, frame clock and data.
   assumes: 64 bit clocks a frame; bit clock stands still between frames. */
`timescale 1ns/100ps
module stx_src (
  output logic bclk,
  output logic fclk,
  output logic sdat
);
  initial begin
    bclk = 1'b0;
    fclk = 1'b0;
    sdat = 1'b0;
  end
  task automatic tick;
    #20 bclk = 1'b1;
    #20 bclk = 1'b0;
  endtask : tick
  task automatic send(input logic [1:0] f, input int w, input logic [23:0] l,
                      input logic [23:0] r);
    logic lv;
    int k;
    // keep pin edges off the sampling clock edge
    #1;
    lv = (f != 2'h0);
    fclk = !lv;
    tick();
    for (int i = 0; i < 64; i++) begin
      fclk = (i < 32) ? lv : !lv;
      k = i % 32 - ((f == 2'h2) ? 32 - w : (f == 2'h1) ? 0 : 1);
      // data moves only while the bit clock is low; idle slots toggle
      sdat = (k >= 0 && k < w) ? ((i < 32) ? l[w-1-k] : r[w-1-k]) : !sdat;
      tick();
    end
  endtask : send
endmodule : stx_src

// ===== verif/stx_serial_in_asserts.sv
/* stx_serial_in_asserts: port checker for stx_serial_in.
   assumes: bound into every stx_serial_in instance. */
`timescale 1ns/100ps
module stx_serial_in_chk
  import stx_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [STX_WORD_W-1:0] sample_left,
  input wire logic [STX_WORD_W-1:0] sample_right,
  input wire logic overflow,
  input wire logic loop_mode,
  input wire logic recovered_clock,
  input wire logic loop_bit_clock,
  input wire logic loop_frame_clock,
  input wire logic loop_serial_out
);
  default clocking @(posedge clock);
  endclocking
  property p_rec;
    disable iff (!rstn || !loop_mode)
    $rose(recovered_clock) |=> !$rose(recovered_clock) [*3] ##1 $rose(recovered_clock);
  endproperty
  a_rec: assert property (p_rec) else $error("recovered period");
  property p_lbc;
    disable iff (!rstn || !loop_mode) $rose(loop_bit_clock) |-> ##32 $rose(loop_bit_clock);
  endproperty
  a_lbc: assert property (p_lbc) else $error("bit clock period");
  property p_duty;
    disable iff (!rstn || !loop_mode)
    $rose(loop_bit_clock) |-> ##15 loop_bit_clock ##1 !loop_bit_clock;
  endproperty
  a_duty: assert property (p_duty) else $error("bit clock duty");
  property p_lfc;
    disable iff (!rstn || !loop_mode) $changed(loop_frame_clock) |-> !loop_bit_clock;
  endproperty
  a_lfc: assert property (p_lfc) else $error("frame clock edge");
  property p_lso;
    disable iff (!rstn || !loop_mode) $changed(loop_serial_out) |-> !loop_bit_clock;
  endproperty
  a_lso: assert property (p_lso) else $error("loop data edge");
  property p_hold;
    disable iff (!rstn) sample_valid && !sample_ready |=>
      sample_valid && $stable(sample_left) && $stable(sample_right);
  endproperty
  a_hold: assert property (p_hold) else $error("sample not held");
  property p_ovf;
    disable iff (!rstn) $rose(overflow) |-> sample_valid;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not full");
  property p_rst;
    !rstn |=> !sample_valid && !overflow && !recovered_clock && !loop_bit_clock;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  c_pop: cover property (sample_valid && sample_ready);
  c_ovf: cover property (overflow);
  c_lfc: cover property ($rose(loop_frame_clock));
endmodule : stx_serial_in_chk
bind stx_serial_in stx_serial_in_chk chk (.clock, .rstn, .sample_valid, .sample_ready,
  .sample_left, .sample_right, .overflow, .loop_mode, .recovered_clock, .loop_bit_clock,
  .loop_frame_clock, .loop_serial_out);

// ===== verif/tb_stx_serial_in.sv
/* tb_stx_serial_in: self-checking bench for the serial audio input stage.
   assumes: stx_src as the audio source, 5 ns clock. */
`timescale 1ns/100ps
module tb_stx_serial_in;
  import stx_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] format_sel = 2'h0;
  logic [1:0] width_sel = 2'h3;
  logic [7:0] biphase_div = 8'h00;
  logic sample_ready = 1'b0;
  logic loop_mode = 1'b0;
  logic loop_serial_bit = 1'b0;
  logic [1:0] osc_r = 2'h0;
  logic bclk, fclk, sdat, biphase_clock, sample_valid, overflow, recovered_clock;
  logic loop_bit_clock, loop_frame_clock, loop_serial_out;
  logic [23:0] sample_left, sample_right;
  int failures = 0;
  int samples_checked = 0;
  int bip_n = 0;
  int lbc_n = 0;
  int lfc_n = 0;
  always #2.5 clock = ~clock;
  always @(posedge clock) osc_r <= osc_r + 2'h1;
  always @(posedge biphase_clock) bip_n++;
  always @(posedge loop_bit_clock) lbc_n++;
  always @(posedge loop_frame_clock) lfc_n++;
  stx_src src (.bclk(bclk), .fclk(fclk), .sdat(sdat));
  stx_serial_in dut (.clock, .rstn, .format_sel, .width_sel, .bit_clock_in(bclk),
    .frame_clock_in(fclk), .serial_audio_line(sdat), .oversample_clock_in(osc_r[1]),
    .biphase_div, .biphase_clock, .sample_valid, .sample_ready, .sample_left,
    .sample_right, .overflow, .loop_mode, .loop_serial_bit, .recovered_clock,
    .loop_bit_clock, .loop_frame_clock, .loop_serial_out);
  task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wait_inc(ref int c, output int n);
    int v;
    v = c;
    for (n = 0; n < 3000 && c == v; n++) @(negedge clock);
  endtask : wait_inc
  task automatic get_pair(input logic [23:0] l, input logic [23:0] r);
    @(negedge clock);
    for (int n = 0; n < 900 && sample_valid !== 1'b1; n++) @(negedge clock);
    cmp("valid", 24'h1, 24'(sample_valid));
    cmp("left", l, sample_left);
    cmp("right", r, sample_right);
    @(posedge clock) sample_ready <= 1'b1;
    @(posedge clock) sample_ready <= 1'b0;
  endtask : get_pair
  task automatic t_formats;
    int w;
    for (int f = 0; f < 3; f++) begin
      for (int j = 0; j < 4; j++) begin
        w = (j == 3) ? 24 : 16 + 2 * j;
        @(posedge clock);
        format_sel <= 2'(f);
        width_sel <= 2'(j);
        src.send(2'(f), w, 24'hc5a3b6 >> (24 - w), 24'hb3c96a >> (24 - w));
        get_pair(24'hc5a3b6 >> (24 - w), 24'hb3c96a >> (24 - w));
      end
    end
  endtask : t_formats
  task automatic t_fifo;
    @(posedge clock);
    format_sel <= 2'h0;
    width_sel <= 2'h3;
    for (int i = 0; i < 17; i++) src.send(2'h0, 24, 24'(i), ~24'(i));
    repeat (2) @(negedge clock);
    cmp("overflow", 24'h1, 24'(overflow));
    for (int i = 0; i < 16; i++) get_pair(24'(i), ~24'(i));
    @(negedge clock);
    cmp("drained", 24'h0, 24'(sample_valid));
  endtask : t_fifo
  task automatic t_biphase;
    int t;
    for (int d = 0; d < 6; d += 5) begin
      @(posedge clock) biphase_div <= 8'(d);
      wait_inc(bip_n, t);
      wait_inc(bip_n, t);
      wait_inc(bip_n, t);
      cmp("biphase period", 24'(8 * (d + 1)), 24'(t));
    end
  endtask : t_biphase
  task automatic t_loop;
    int b;
    int t;
    @(posedge clock);
    loop_mode <= 1'b1;
    loop_serial_bit <= 1'b1;
    wait_inc(lfc_n, t);
    b = lbc_n;
    wait_inc(lfc_n, t);
    cmp("bits per frame", 24'(STX_LOOP_BCLK_RATIO), 24'(lbc_n - b));
    cmp("loop data", 24'h1, 24'(loop_serial_out));
    @(posedge clock) loop_serial_bit <= 1'b0;
    repeat (40) @(negedge clock);
    cmp("loop data", 24'h0, 24'(loop_serial_out));
    @(posedge clock) loop_mode <= 1'b0;
  endtask : t_loop
  task automatic give_verdict;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    t_formats();
    t_fifo();
    t_biphase();
    t_loop();
    give_verdict();
  end
  initial begin
    #400000;
    failures++;
    give_verdict();
  end
endmodule : tb_stx_serial_in
